// ===== design/sdi_pkg.sv
// Constants, register map and types of the servo digital input block
package sdi_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_SELECT = 4'h8;
	localparam logic [ADDR_W-1:0] REG_CMD    = 4'hC;
	// Control register fields
	localparam int CTRL_ANALOG_DIG = 0;
	localparam int CTRL_ENC_EMU    = 1;
	localparam int CTRL_DOUT12     = 2;
	localparam int CTRL_NC_CONTACT = 3;
	localparam int CTRL_NODE_OFS   = 4;
	localparam int CTRL_POS_MODE   = 5;
	localparam int CTRL_W          = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h28;
	// Command register fields (write one, self clearing)
	localparam int CMD_ERROR  = 0;
	localparam int CMD_AT_0   = 1;
	localparam int CMD_INIT_D = 2;
	// Status register fields
	localparam int ST_STATE_LO  = 0;
	localparam int ST_PWR       = 3;
	localparam int ST_LOOP      = 4;
	localparam int ST_POS_OK    = 5;
	localparam int ST_NEG_OK    = 6;
	localparam int ST_LIM_STOP  = 7;
	localparam int ST_START_CNT = 8;
	localparam int SEL_W   = 6;
	localparam int DEST_W  = 4;
	localparam int GROUP_W = 2;
	localparam int NODE_W  = 8;
	localparam int SYNC_W  = 10;
	localparam int CNT_W   = 8;
	// Control loop initialization time and its cycle count at 20 MHz
	localparam int CLK_HZ       = 20000000;
	localparam int INIT_TIME_US = 100;
	localparam int INIT_CYCLES  = INIT_TIME_US * (CLK_HZ / 1000000);
	localparam int INIT_CNT_W   = 12;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_INIT,
		ST_ACTIVE,
		ST_DECEL,
		ST_ERROR
	} sdi_state_type;
endpackage

// ===== design/sdi_top.sv
// Digital input decoder of a servo positioning controller
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module sdi_top (
	input  wire logic                       clock,
	input  wire logic                       rstn,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [sdi_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [31:0]                wb_dat_i,
	input  wire logic [3:0]                 wb_sel_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	input  wire logic                       dest_sel_bit0,
	input  wire logic                       dest_sel_bit1,
	input  wire logic                       dest_sel_bit2,
	input  wire logic                       dest_sel_bit3,
	input  wire logic                       group_sel_bit0,
	input  wire logic                       group_sel_bit1,
	input  wire logic                       position_start_input,
	input  wire logic                       negative_limit_input,
	input  wire logic                       positive_limit_input,
	input  wire logic                       controller_enable_input,
	input  wire logic [sdi_pkg::NODE_W-1:0] node_base,
	output logic      [sdi_pkg::SEL_W-1:0]  target_index,
	output logic      [sdi_pkg::GROUP_W-1:0] param_group,
	output logic      [sdi_pkg::DEST_W-1:0] destination,
	output logic                            start_run,
	output logic                            pos_setpoint_ok,
	output logic                            neg_setpoint_ok,
	output logic                            limit_decel,
	output logic                            loop_init,
	output logic                            loop_enable,
	output logic                            power_stage_on,
	output logic                            decel_to_zero,
	output logic                            error_ack,
	output logic                            ready_op,
	output logic      [sdi_pkg::NODE_W-1:0] node_number
);
	import sdi_pkg::*;

	// Two-stage synchronisers on all ten inputs
	logic [SYNC_W-1:0] pin_w;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [SYNC_W-1:0] prev_r;
	assign pin_w = {controller_enable_input, positive_limit_input,
		negative_limit_input, position_start_input, group_sel_bit1,
		group_sel_bit0, dest_sel_bit3, dest_sel_bit2, dest_sel_bit1,
		dest_sel_bit0};

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= pin_w;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// Edges taken only on synchronised samples, so each is seen once
	wire start_rise_w = sync2_r[6] & ~prev_r[6];
	wire en_rise_w    = sync2_r[9] & ~prev_r[9];
	wire en_fall_w    = ~sync2_r[9] & prev_r[9];

	// Register bus
	logic [CTRL_W-1:0] ctrl_r;
	logic              ack_r;
	logic [31:0]       rdata_r;
	logic              err_r;
	logic              at_zero_r;
	logic              init_done_r;
	wire bus_req_w   = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr_w        = bus_req_w & wb_we_i & wb_sel_i[0];
	wire wr_ctrl_w   = wr_w & (wb_adr_i == REG_CTRL);
	wire wr_cmd_w    = wr_w & (wb_adr_i == REG_CMD);

	// Availability of each selector line
	wire low_avail_w = ctrl_r[CTRL_ANALOG_DIG];
	wire mid_block_w = ctrl_r[CTRL_ENC_EMU]
		| ctrl_r[CTRL_DOUT12];
	wire [SEL_W-1:0] sel_mask_w = {2'b11, ~mid_block_w, ~mid_block_w,
		2'b11} & {2'b11, {DEST_W{low_avail_w}}};
	wire [SEL_W-1:0] sel_w = sync2_r[SEL_W-1:0] & sel_mask_w;

	// Passive level: high for NC contact, low for NO contact
	wire nc_w       = ctrl_r[CTRL_NC_CONTACT];
	wire neg_pass_w = ~(sync2_r[7] ^ nc_w);
	wire pos_pass_w = ~(sync2_r[8] ^ nc_w);

	// Enable state machine
	sdi_state_type      state_r;
	sdi_state_type      state_nxt;
	logic [INIT_CNT_W-1:0] init_cnt_r;
	logic               lim_hit_r;
	logic               lim_dir_pos_r;
	logic               pos_clear_r;
	logic               neg_clear_r;
	logic [CNT_W-1:0]   start_cnt_r;

	wire init_end_w = (init_cnt_r == INIT_CNT_W'(INIT_CYCLES - 1))
		| init_done_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (err_r)
					state_nxt = ST_ERROR;
				else if (en_rise_w)
					state_nxt = ST_INIT;
			end
			ST_INIT: begin
				if (err_r)
					state_nxt = ST_ERROR;
				else if (en_fall_w)
					state_nxt = ST_OFF;
				else if (init_end_w)
					state_nxt = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (err_r)
					state_nxt = ST_ERROR;
				else if (en_fall_w && !lim_hit_r)
					state_nxt = ST_DECEL;
			end
			ST_DECEL: begin
				if (err_r)
					state_nxt = ST_ERROR;
				else if (at_zero_r)
					state_nxt = ST_OFF;
			end
			ST_ERROR: begin
				if (en_fall_w)
					state_nxt = ST_OFF;
			end
			default: state_nxt = ST_OFF;
		endcase
	end

	wire ack_evt_w = (state_r == ST_ERROR) & en_fall_w;
	wire active_w  = (state_r == ST_ACTIVE);
	wire neg_ok_w  = neg_pass_w | neg_clear_r;
	wire pos_ok_w  = pos_pass_w | pos_clear_r;
	wire lim_now_w = active_w & (~neg_pass_w | ~pos_pass_w);
	wire [NODE_W-1:0] ofs_w = ctrl_r[CTRL_NODE_OFS] ?
		{{(NODE_W-DEST_W){1'b0}}, sel_w[DEST_W-1:0]} : '0;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r    <= ST_OFF;
			init_cnt_r <= '0;
		end else begin
			state_r    <= state_nxt;
			init_cnt_r <= (state_r == ST_INIT) ?
				init_cnt_r + 1'b1 : '0;
		end
	end

	// Error and motion feedback flags; the set wins over the clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			err_r       <= 1'b0;
			at_zero_r   <= 1'b0;
			init_done_r <= 1'b0;
		end else begin
			if (wr_cmd_w && wb_dat_i[CMD_ERROR])
				err_r <= 1'b1;
			else if (ack_evt_w)
				err_r <= 1'b0;
			at_zero_r   <= wr_cmd_w & wb_dat_i[CMD_AT_0];
			init_done_r <= wr_cmd_w & wb_dat_i[CMD_INIT_D];
		end
	end

	// Limit stop bookkeeping: enable fall after a hit clears the stop
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lim_hit_r     <= 1'b0;
			lim_dir_pos_r <= 1'b0;
			pos_clear_r   <= 1'b0;
			neg_clear_r   <= 1'b0;
		end else begin
			if (lim_now_w && !lim_hit_r && !pos_clear_r && !neg_clear_r) begin
				lim_hit_r     <= 1'b1;
				lim_dir_pos_r <= ~pos_pass_w;
			end else if (lim_hit_r && en_fall_w) begin
				lim_hit_r   <= 1'b0;
				pos_clear_r <= lim_dir_pos_r;
				neg_clear_r <= ~lim_dir_pos_r;
			end
			if (pos_clear_r && pos_pass_w)
				pos_clear_r <= 1'b0;
			if (neg_clear_r && neg_pass_w)
				neg_clear_r <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			target_index    <= '0;
			param_group     <= '0;
			destination     <= '0;
			start_run       <= 1'b0;
			start_cnt_r     <= '0;
			pos_setpoint_ok <= 1'b0;
			neg_setpoint_ok <= 1'b0;
			limit_decel     <= 1'b0;
			loop_init       <= 1'b0;
			loop_enable     <= 1'b0;
			power_stage_on  <= 1'b0;
			decel_to_zero   <= 1'b0;
			error_ack       <= 1'b0;
			ready_op        <= 1'b0;
			node_number     <= '0;
		end else begin
			// Selection latched on the start edge is the level sampled in the same cycle as it
			if (start_rise_w && active_w && ctrl_r[CTRL_POS_MODE]) begin
				target_index <= sel_w;
				param_group  <= sel_w[SEL_W-1:DEST_W];
				destination  <= sel_w[DEST_W-1:0];
				start_cnt_r  <= start_cnt_r + 1'b1;
			end
			start_run       <= start_rise_w & active_w
				& ctrl_r[CTRL_POS_MODE];
			pos_setpoint_ok <= pos_ok_w;
			neg_setpoint_ok <= neg_ok_w;
			limit_decel     <= lim_hit_r;
			loop_init       <= (state_nxt == ST_INIT);
			loop_enable     <= (state_nxt == ST_ACTIVE);
			// Power held through limit stop and deceleration
			power_stage_on  <= (state_nxt == ST_ACTIVE)
				| (state_nxt == ST_DECEL);
			decel_to_zero   <= (state_nxt == ST_DECEL);
			error_ack       <= ack_evt_w;
			ready_op        <= (state_nxt != ST_ERROR);
			node_number     <= node_base + ofs_w;
		end
	end

	// Wishbone slave: one wait state, ack one cycle, unmapped reads zero
	wire [31:0] status_w = {16'h0000, start_cnt_r, lim_hit_r,
		neg_ok_w, pos_ok_w, loop_enable, power_stage_on, 3'(state_r)};
	wire [31:0] rmux_w =
		(wb_adr_i == REG_CTRL)   ? {26'h0, ctrl_r} :
		(wb_adr_i == REG_STATUS) ? status_w :
		(wb_adr_i == REG_SELECT) ? {18'h0, sync2_r[9:6], 4'h0, sel_w} :
		32'h0000_0000;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_r  <= CTRL_RESET;
			ack_r   <= 1'b0;
			rdata_r <= '0;
		end else begin
			ack_r <= bus_req_w;
			if (bus_req_w)
				rdata_r <= rmux_w;
			if (wr_ctrl_w)
				ctrl_r <= wb_dat_i[CTRL_W-1:0];
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;
endmodule

// ===== tb/sdi_ctl_model.sv
// Behavioural machine controller driving the servo input pins
`timescale 1ns/1ps
module sdi_ctl_model (
	input  wire logic [5:0] sel_req,
	input  wire logic       start_req,
	input  wire logic       neg_req,
	input  wire logic       pos_req,
	input  wire logic       en_req,
	output logic            dest_sel_bit0,
	output logic            dest_sel_bit1,
	output logic            dest_sel_bit2,
	output logic            dest_sel_bit3,
	output logic            group_sel_bit0,
	output logic            group_sel_bit1,
	output logic            position_start_input,
	output logic            negative_limit_input,
	output logic            positive_limit_input,
	output logic            controller_enable_input
);
	assign {group_sel_bit1, group_sel_bit0, dest_sel_bit3, dest_sel_bit2,
		dest_sel_bit1, dest_sel_bit0} = sel_req;
	assign position_start_input = start_req;
	assign negative_limit_input = neg_req;
	assign positive_limit_input = pos_req;
	// Power returns only after this side gives a fresh rise
	assign controller_enable_input = en_req;
endmodule

// ===== tb/sdi_top_props.sv
// Port assertions of the servo digital input block
`timescale 1ns/1ps
module sdi_props (
	input wire logic                        clock,
	input wire logic                        rstn,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_ack_o,
	input wire logic [sdi_pkg::SEL_W-1:0]   target_index,
	input wire logic [sdi_pkg::GROUP_W-1:0] param_group,
	input wire logic [sdi_pkg::DEST_W-1:0]  destination,
	input wire logic                        start_run,
	input wire logic                        limit_decel,
	input wire logic                        loop_init,
	input wire logic                        loop_enable,
	input wire logic                        power_stage_on,
	input wire logic                        decel_to_zero,
	input wire logic                        error_ack,
	input wire logic                        ready_op
);
	import sdi_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_index_join: assert property (target_index == {param_group, destination})
		else $error("index not group and destination");
	a_start_active: assert property (start_run |-> power_stage_on && loop_enable)
		else $error("start while not enabled");
	a_start_once: assert property (start_run |=> !start_run)
		else $error("start pulse too long");
	a_loop_first: assert property ($rose(loop_enable) |-> $past(loop_init))
		else $error("loop enabled without init");
	a_power_kept: assert property (limit_decel && $past(power_stage_on) |-> power_stage_on)
		else $error("power dropped in limit stop");
	a_decel_first: assert property ($fell(power_stage_on) && ready_op |-> $past(decel_to_zero))
		else $error("power off without deceleration");
	a_ack_ready: assert property (error_ack |=> ready_op && !error_ack)
		else $error("acknowledge did not give ready");
	c_start: cover property (start_run);
	c_ack: cover property (error_ack);
	c_limit: cover property (limit_decel);
endmodule
bind sdi_top sdi_props i_props (.*);

// ===== tb/sdi_top_tb.sv
// Self-checking bench of the servo digital input block
`timescale 1ns/1ps
module sdi_top_tb;
	import sdi_pkg::*;
	logic              clock = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic              wb_we_i = 0, wb_ack_o;
	logic [ADDR_W-1:0] wb_adr_i = '0;
	logic [31:0]       wb_dat_i = '0, wb_dat_o, rdat;
	logic [3:0]        wb_sel_i = '0;
	logic [5:0]        sel_req = '0, target_index;
	logic              start_req = 0, neg_req = 1, pos_req = 1, en_req = 0;
	logic              dest_sel_bit0, dest_sel_bit1, dest_sel_bit2;
	logic              dest_sel_bit3, group_sel_bit0, group_sel_bit1;
	logic              position_start_input, negative_limit_input;
	logic              positive_limit_input, controller_enable_input;
	logic [7:0]        node_base = '0, node_number;
	logic [1:0]        param_group;
	logic [3:0]        destination;
	logic              start_run, pos_setpoint_ok, neg_setpoint_ok;
	logic              limit_decel, loop_init, loop_enable, power_stage_on;
	logic              decel_to_zero, error_ack, ready_op;
	int                failures = 0, n_compared = 0, cycles = 0;
	logic              ack_seen = 1'b0;
	logic [5:0]        ctl_tab [4] = '{6'h28, 6'h29, 6'h2B, 6'h2D};
	logic [5:0]        sel_tab [4] = '{6'h30, 6'h3F, 6'h33, 6'h33};
	sdi_ctl_model i_model (.*);
	sdi_top i_dut (.*);
	always #25 clock = ~clock;
	task automatic conclude();
		if (failures == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Acknowledge is a one-cycle pulse, so it is caught here
	always @(posedge clock) begin
		if (error_ack === 1'b1)
			ack_seen <= 1'b1;
	end
	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [3:0] a);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clock);
	endtask
	initial begin
		pause(10);
		rstn <= 1'b1;
		@(posedge clock);
		bus(1'b1, REG_CTRL, 32'h0, 4'h0);
		rd(REG_CTRL);
		check(rdat, 32'h28);
		rd(4'h2);
		check(rdat, 32'h0);
		sel_req <= 6'h3F;
		for (int i = 0; i < 4; i++) begin
			wr(REG_CTRL, 32'(ctl_tab[i]));
			pause(6);
			rd(REG_SELECT);
			check(rdat & 32'h3F, 32'(sel_tab[i]));
		end
		wr(REG_CTRL, 32'h39);
		node_base <= 8'h10;
		pause(6);
		check(32'(node_number), 32'h1F);
		wr(REG_CTRL, 32'h21);
		pause(6);
		check(32'({pos_setpoint_ok, neg_setpoint_ok}), 32'h0);
		wr(REG_CTRL, 32'h29);
		en_req <= 1'b1;
		pause(6);
		check(32'({pos_setpoint_ok, neg_setpoint_ok}), 32'h3);
		check(32'({loop_init, power_stage_on}), 32'h2);
		wr(REG_CMD, 32'h4);
		pause(3);
		check(32'({loop_enable, power_stage_on}), 32'h3);
		sel_req <= 6'h2A;
		pause(6);
		start_req <= 1'b1;
		pause(6);
		start_req <= 1'b0;
		check(32'(target_index), 32'h2A);
		check(32'({param_group, destination}), 32'h2A);
		rd(REG_STATUS);
		check(rdat & 32'hFF00, 32'h100);
		en_req <= 1'b0;
		pause(6);
		check(32'({decel_to_zero, power_stage_on}), 32'h3);
		wr(REG_CMD, 32'h2);
		pause(3);
		check(32'(power_stage_on), 32'h0);
		en_req <= 1'b1;
		pause(6);
		wr(REG_CMD, 32'h4);
		pause(3);
		pos_req <= 1'b0;
		pause(6);
		check(32'({pos_setpoint_ok, neg_setpoint_ok, limit_decel,
			power_stage_on}), 32'h7);
		en_req <= 1'b0;
		pause(6);
		check(32'(pos_setpoint_ok), 32'h1);
		pos_req <= 1'b1;
		wr(REG_CMD, 32'h1);
		pause(3);
		check(32'(ready_op), 32'h0);
		check(32'(ack_seen), 32'h0);
		en_req <= 1'b1;
		pause(6);
		en_req <= 1'b0;
		pause(6);
		check(32'({ready_op, power_stage_on}), 32'h2);
		check(32'(ack_seen), 32'h1);
		en_req <= 1'b1;
		pause(6);
		check(32'(loop_init), 32'h1);
		conclude();
	end
endmodule
